//--- pkg/rx_id_pkg.sv
// package for the receive-buffer identifier register block
package rx_id_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses inside the device)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_BUF0_ID_HIGH = 8'h61;
   localparam logic [7:0] ADDR_BUF0_ID_LOW = 8'h62;
   localparam logic [7:0] ADDR_BUF1_ID_HIGH = 8'h71;
   localparam logic [7:0] ADDR_BUF1_ID_LOW = 8'h72;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [7:0] RD_RESET_VALUE = 8'h00;
   // ---------------------------------------------------------------
   // low byte field positions
   // ---------------------------------------------------------------
   localparam int LOW_STD_ID_MSB = 7;
   localparam int LOW_STD_ID_LSB = 5;
   localparam int LOW_REMOTE_BIT = 4;
   localparam int LOW_EXT_FLAG_BIT = 3;
   localparam int LOW_UNUSED_BIT = 2;
   localparam int LOW_EXT_ID_MSB = 1;
   localparam int LOW_EXT_ID_LSB = 0;
   // ---------------------------------------------------------------
   // standard identifier split between the two bytes
   // ---------------------------------------------------------------
   localparam int STD_ID_MSB = 10;
   localparam int STD_ID_SPLIT = 3;
   localparam int STD_ID_LOW_MSB = 2;
   localparam int STD_ID_LSB = 0;
   localparam int NUM_BUFS = 2;

   // frame fields handed over by the receive engine
   typedef struct packed {
      logic [10:0] standard_identifier;
      logic std_remote_request_flag;
      logic extended_flag;
      logic [1:0] extended_identifier;
   } rx_frame_id_t;
endpackage

//--- src/can_rx_identifier_regs.sv
// identifier registers of the two receive buffers, read-only to host
`timescale 1ns/10ps
module can_rx_identifier_regs (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [1:0] store_en,
   input wire rx_id_pkg::rx_frame_id_t store_frame,
   input wire logic [7:0] rd_addr,
   input wire logic rd_en,
   output logic [7:0] rd_data
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // two bytes per buffer, written only by the receive engine
   logic [7:0] id_high_q [rx_id_pkg::NUM_BUFS];
   logic [7:0] rx_std_id_low_reg_q [rx_id_pkg::NUM_BUFS];
   // byte images of the frame on store_frame, shared by both buffers
   logic [7:0] id_high_d;
   logic [7:0] id_low_d;
   // read path and the address classes that the checks lean on
   logic [7:0] rd_data_d;
   logic rd_mapped;
   logic rd_low_byte;

   // ---------------------------------------------------------------
   // frame to register images
   // ---------------------------------------------------------------
   // top eight identifier bits make the whole high byte
   always_comb begin
      id_high_d = store_frame.standard_identifier[
         rx_id_pkg::STD_ID_MSB:rx_id_pkg::STD_ID_SPLIT];
   end

   // low byte packs the rest; the unused bit is built as zero here,
   // so a read of the low byte never loses a bit to a patch
   always_comb begin
      id_low_d = '0;
      id_low_d[rx_id_pkg::LOW_STD_ID_MSB:rx_id_pkg::LOW_STD_ID_LSB] =
         store_frame.standard_identifier[
         rx_id_pkg::STD_ID_LOW_MSB:rx_id_pkg::STD_ID_LSB];
      // remote flag kept as received, even for extended frames
      id_low_d[rx_id_pkg::LOW_REMOTE_BIT] =
         store_frame.std_remote_request_flag;
      id_low_d[rx_id_pkg::LOW_EXT_FLAG_BIT] =
         store_frame.extended_flag;
      id_low_d[rx_id_pkg::LOW_UNUSED_BIT] = 1'b0;
      id_low_d[rx_id_pkg::LOW_EXT_ID_MSB:rx_id_pkg::LOW_EXT_ID_LSB] =
         store_frame.extended_identifier;
   end

   // ---------------------------------------------------------------
   // per-buffer storage
   // ---------------------------------------------------------------
   // both buffers see the same frame images; only the strobe picks
   // which one takes them, so a double store costs no extra logic
   genvar b;
   generate
      for (b = 0; b < rx_id_pkg::NUM_BUFS; b++) begin : g_buf
         // contents stay undefined until a frame lands, so no reset;
         // a reset in mid-run leaves the last frame readable
         always_ff @(posedge ref_clk) begin
            if (store_en[b]) begin
               id_high_q[b] <= id_high_d;
               rx_std_id_low_reg_q[b] <= id_low_d;
            end
         end

         // high byte takes identifier bits 10..3
         a_high_byte_store: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> id_high_q[b] == $past(
               store_frame.standard_identifier[rx_id_pkg::STD_ID_MSB:
               rx_id_pkg::STD_ID_SPLIT]))
            else $error("high id byte not stored");

         // low identifier bits sit at the top of the low byte
         a_low_id_store: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> rx_std_id_low_reg_q[b][
               rx_id_pkg::LOW_STD_ID_MSB:rx_id_pkg::LOW_STD_ID_LSB] ==
               $past(store_frame.standard_identifier[
               rx_id_pkg::STD_ID_LOW_MSB:rx_id_pkg::STD_ID_LSB]))
            else $error("low id bits not stored");

         // remote flag follows the received frame
         a_remote_store: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> rx_std_id_low_reg_q[b][
               rx_id_pkg::LOW_REMOTE_BIT] ==
               $past(store_frame.std_remote_request_flag))
            else $error("remote flag wrong");

         // format flag follows the received frame
         a_ext_flag_store: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> rx_std_id_low_reg_q[b][
               rx_id_pkg::LOW_EXT_FLAG_BIT] ==
               $past(store_frame.extended_flag))
            else $error("extended flag wrong");

         // unused slot is stored as zero
         a_unused_stored: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> rx_std_id_low_reg_q[b][
               rx_id_pkg::LOW_UNUSED_BIT] == 1'b0)
            else $error("unused bit stored nonzero");

         // two top extended bits fill the bottom of the low byte
         a_ext_id_store: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            store_en[b] |=> rx_std_id_low_reg_q[b][
               rx_id_pkg::LOW_EXT_ID_MSB:rx_id_pkg::LOW_EXT_ID_LSB] ==
               $past(store_frame.extended_identifier))
            else $error("extended id bits wrong");

         // without a strobe the buffer keeps its frame
         a_store_hold: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            rst_n && !store_en[b] |=> $stable(id_high_q[b]) &&
               $stable(rx_std_id_low_reg_q[b]))
            else $error("buffer changed without store");
      end
   endgenerate

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------
   // unmapped addresses answer zero rather than echoing old data
   always_comb begin
      case (rd_addr)
         rx_id_pkg::ADDR_BUF0_ID_HIGH: rd_data_d = id_high_q[0];
         rx_id_pkg::ADDR_BUF0_ID_LOW: rd_data_d = rx_std_id_low_reg_q[0];
         rx_id_pkg::ADDR_BUF1_ID_HIGH: rd_data_d = id_high_q[1];
         rx_id_pkg::ADDR_BUF1_ID_LOW: rd_data_d = rx_std_id_low_reg_q[1];
         default: rd_data_d = rx_id_pkg::READ_UNMAPPED;
      endcase
   end

   // address classes, read only by the checks
   always_comb begin
      rd_low_byte = (rd_addr == rx_id_pkg::ADDR_BUF0_ID_LOW) ||
         (rd_addr == rx_id_pkg::ADDR_BUF1_ID_LOW);
      rd_mapped = rd_low_byte ||
         (rd_addr == rx_id_pkg::ADDR_BUF0_ID_HIGH) ||
         (rd_addr == rx_id_pkg::ADDR_BUF1_ID_HIGH);
   end

   // read data is registered, one cycle after rd_en; it stands until
   // the next strobe or reset, so a slow host may pick it up late
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data <= rx_id_pkg::RD_RESET_VALUE;
      end else if (rd_en) begin
         rd_data <= rd_data_d;
      end
   end

   // ---------------------------------------------------------------
   // read checks
   // ---------------------------------------------------------------
   // high byte of buffer 0 comes back as stored
   a_high_read_path: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      rd_en && rd_addr == rx_id_pkg::ADDR_BUF0_ID_HIGH && !store_en[0]
      |=> rd_data == id_high_q[0])
      else $error("high byte read mismatch");

   // low byte of buffer 1 comes back as stored
   a_low_read_path: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      rd_en && rd_addr == rx_id_pkg::ADDR_BUF1_ID_LOW && !store_en[1]
      |=> rd_data == rx_std_id_low_reg_q[1])
      else $error("low byte read mismatch");

   // unused bit of a low byte always reads zero
   a_unused_bit_zero: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      rd_en && rd_low_byte |=> rd_data[rx_id_pkg::LOW_UNUSED_BIT] == 1'b0)
      else $error("unused bit read nonzero");

   // gaps in the map answer zero
   a_unmapped_zero: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      rd_en && !rd_mapped |=> rd_data == rx_id_pkg::READ_UNMAPPED)
      else $error("unmapped read nonzero");

   // read data stands while no strobe comes
   a_read_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rst_n && !rd_en |=> $stable(rd_data))
      else $error("read data moved without strobe");

   // reset clears the read data, no disable here on purpose
   a_reset_clear: assert property (@(posedge ref_clk)
      !rst_n |=> rd_data == rx_id_pkg::RD_RESET_VALUE)
      else $error("read data not cleared by reset");

   // ---------------------------------------------------------------
   // coverage of the main scenarios
   // ---------------------------------------------------------------
   // extended frame landing in buffer 0
   c_store_ext: cover property (@(posedge ref_clk)
      store_en[0] && store_frame.extended_flag);
   // frame with the remote flag set, standard or extended, landing in buffer 1
   c_store_remote: cover property (@(posedge ref_clk)
      store_en[1] && store_frame.std_remote_request_flag);
   // host reading a low byte
   c_read_low: cover property (@(posedge ref_clk)
      rd_en && rd_addr == rx_id_pkg::ADDR_BUF0_ID_LOW);
   // both buffers filled by one strobe
   c_store_both: cover property (@(posedge ref_clk)
      &store_en);
   // read right after a reset ends
   c_read_after_reset: cover property (@(posedge ref_clk)
      $rose(rst_n) && rd_en);
endmodule // can_rx_identifier_regs

//--- testbench/host_reader.sv
// host side model that reads the identifier registers
`timescale 1ns/10ps
module host_reader (
   input wire logic ref_clk,
   output logic [7:0] rd_addr = 8'h00,
   output logic rd_en = 1'b0,
   input wire logic [7:0] rd_data
);
   // strobe one edge; registered data stands at the next rising edge
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      rd_addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(posedge ref_clk);
      d = rd_data;
   endtask
   // remote flag counts only when the extended flag is clear
   function automatic logic remote_seen(input logic [7:0] lo);
      return lo[4] & ~lo[3];
   endfunction
endmodule // host_reader

//--- testbench/tb.sv
// self-checking bench for the receive identifier registers
`timescale 1ns/10ps
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] store_en = 2'h0;
   rx_id_pkg::rx_frame_id_t store_frame = '0;
   logic [7:0] rd_addr, rd_data;
   logic rd_en;
   int err_total = 0, tests_run = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   can_rx_identifier_regs uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .store_en(store_en), .store_frame(store_frame), .rd_addr(rd_addr),
      .rd_en(rd_en), .rd_data(rd_data));
   host_reader host (.ref_clk(ref_clk), .rd_addr(rd_addr), .rd_en(rd_en),
      .rd_data(rd_data));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic store(logic [1:0] m, rx_id_pkg::rx_frame_id_t f);
      store_en <= m;
      store_frame <= f;
      @(posedge ref_clk);
      store_en <= 2'h0;
      @(posedge ref_clk);
   endtask
   // both bytes of one buffer against the frame that went in
   task automatic rd_buf(logic [7:0] a, rx_id_pkg::rx_frame_id_t f);
      logic [7:0] d;
      host.read(a, d);
      chk("id_high", f.standard_identifier[10:3], d);
      host.read(a + 8'h01, d);
      chk("id_low", {f.standard_identifier[2:0], f.std_remote_request_flag,
         f.extended_flag, 1'b0, f.extended_identifier}, d);
      chk("remote_seen",
         {7'h00, f.std_remote_request_flag & ~f.extended_flag},
         {7'h00, host.remote_seen(d)});
   endtask
   // same-cycle store, then buffer 1 alone gets an extended frame
   task automatic both_then_one();
      rx_id_pkg::rx_frame_id_t a = '{11'h5a3, 1'b1, 1'b0, 2'b01};
      rx_id_pkg::rx_frame_id_t b = '{11'h2c7, 1'b0, 1'b1, 2'b10};
      store(2'h3, a);
      store(2'h2, b);
      rd_buf(rx_id_pkg::ADDR_BUF0_ID_HIGH, a);
      rd_buf(rx_id_pkg::ADDR_BUF1_ID_HIGH, b);
   endtask
   // data frame overwrites buffer 0; a gap address reads zero
   task automatic overwrite_gap();
      rx_id_pkg::rx_frame_id_t c = '{11'h7ff, 1'b0, 1'b0, 2'b11};
      logic [7:0] d;
      store(2'h1, c);
      rd_buf(rx_id_pkg::ADDR_BUF0_ID_HIGH, c);
      host.read(8'h63, d);
      chk("unmapped", rx_id_pkg::READ_UNMAPPED, d);
   endtask
   // extended remote frame into buffer 0, kept across a mid-run reset
   task automatic reset_keeps();
      rx_id_pkg::rx_frame_id_t e = '{11'h123, 1'b1, 1'b1, 2'b00};
      store(2'h1, e);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("rd_data_reset", rx_id_pkg::RD_RESET_VALUE, rd_data);
      rst_n <= 1'b1;
      rd_buf(rx_id_pkg::ADDR_BUF0_ID_HIGH, e);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hang guard, far beyond the few dozen cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      chk("rd_data_reset", rx_id_pkg::RD_RESET_VALUE, rd_data);
      rst_n <= 1'b1;
      both_then_one();
      overwrite_gap();
      reset_keeps();
      finish_test();
   end
endmodule // tb
